// >>> dv/topc_pin_model.sv
/* Far-side source of the two capture pin levels.
   Assumes one bench process calls its task. */
`default_nettype none
module topc_pin_model (
   // Clock
   input wire logic pclk,
   // Capture pins
   output var logic first_capture_input,
   output var logic second_capture_input
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels move only on command: a stray edge would retrigger
   initial begin
      first_capture_input = 1'b0;
      second_capture_input = 1'b0;
   end
   task automatic set_pin(input logic sel, input logic lvl);
      @(posedge pclk);
      if (sel) begin
         second_capture_input <= lvl;
      end else begin
         first_capture_input <= lvl;
      end
   endtask
endmodule // topc_pin_model
`default_nettype wire

// >>> dv/topc_timer_asserts.sv
/* Checker for the timer's bus answers, events and pins.
   Assumes one pclk domain and binding to topc_timer. */
`default_nettype none
module topc_timer_chk (
   // Clock and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and events
   input wire logic second_capture_input,
   input wire logic timer_output_pin,
   input wire logic first_match_irq,
   input wire logic second_match_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_follows_a:
      assert property (psel && penable && !pready |=> pready)
      else $error("no ready after access");
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a:
      assert property (pready |-> $past(penable) && psel)
      else $error("ready without access");
   refused_zero_a:
      assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access not clean");
   first_irq_pulse_a:
      assert property (first_match_irq |=> !first_match_irq)
      else $error("first event too long");
   second_irq_pulse_a:
      assert property (second_match_irq |=> !second_match_irq)
      else $error("second event too long");
   sync_delay_a:
      assert property ($rose(second_capture_input) |-> !first_match_irq[*3])
      else $error("capture event before sync delay");
   reset_quiet_a:
      assert property ($rose(presetn) |-> !pready && !timer_output_pin)
      else $error("outputs active after reset");
endmodule // topc_timer_chk

bind topc_timer topc_timer_chk chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .second_capture_input(second_capture_input),
   .timer_output_pin(timer_output_pin), .first_match_irq(first_match_irq),
   .second_match_irq(second_match_irq));
`default_nettype wire

// >>> dv/topc_timer_tb.sv
/* Self-checking bench for topc_timer with an APB master and pin model.
   Assumes the register map and one-wait-state bus answer of topc_timer. */
`default_nettype none
`include "topc_consts.vh"
module topc_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, ra;
   logic first_capture_input, second_capture_input;
   logic timer_output_pin, first_match_irq, second_match_irq;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int irq1_cnt = 0;
   int irq2_cnt = 0;
   topc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_capture_input(first_capture_input),
      .second_capture_input(second_capture_input),
      .timer_output_pin(timer_output_pin),
      .first_match_irq(first_match_irq), .second_match_irq(second_match_irq));
   topc_pin_model pins (.pclk(pclk), .first_capture_input(first_capture_input),
      .second_capture_input(second_capture_input));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Whole run is about 66k cycles; the ceiling leaves margin
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         num_errors = num_errors + 1;
         report_and_stop();
      end
   end
   // Events stand one pclk, so they are counted rather than sampled
   always @(posedge pclk) begin
      if (first_match_irq === 1'b1)
         irq1_cnt <= irq1_cnt + 1;
      if (second_match_irq === 1'b1)
         irq2_cnt <= irq2_cnt + 1;
   end
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Stop first: edge selection may only change while stopped
   task automatic setup(input logic [31:0] cc, es, oc, md);
      apb(1'b1, `TOPC_OFF_MODE, 32'h0);
      apb(1'b1, `TOPC_OFF_CAPCMP, cc);
      apb(1'b1, `TOPC_OFF_EDGE, es);
      apb(1'b1, `TOPC_OFF_OUT, oc);
      apb(1'b1, `TOPC_OFF_MODE, md);
   endtask
   task automatic wait_level(input logic lvl, output int n);
      n = 0;
      while (timer_output_pin !== lvl) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic read_diff(output logic [31:0] diff);
      apb(1'b0, `TOPC_OFF_FIRST, 32'h0);
      ra = rd;
      apb(1'b0, `TOPC_OFF_SECOND, 32'h0);
      diff = {16'h0, ra[15:0] - rd[15:0]};
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 32; i += 4) begin
         apb(1'b0, i[7:0], 32'h0);
         chk("reset value", 32'h0, rd);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask
   task automatic t_ppg();
      int h, l;
      apb(1'b1, `TOPC_OFF_FIRST, 32'h9);
      apb(1'b1, `TOPC_OFF_SECOND, 32'h3);
      setup(32'h0, 32'h0, 32'h13, 32'hc);
      wait_level(1'b1, h);
      wait_level(1'b0, h);
      wait_level(1'b1, l);
      wait_level(1'b0, h);
      chk("ppg high", 32'h4, h);
      chk("ppg period", 32'ha, h + l);
   endtask
   task automatic t_oneshot();
      int d, w;
      apb(1'b1, `TOPC_OFF_FIRST, 32'h4);
      apb(1'b1, `TOPC_OFF_SECOND, 32'ha);
      setup(32'h0, 32'h1, 32'h33, 32'h4);
      apb(1'b1, `TOPC_OFF_OUT, 32'h73);
      wait_level(1'b1, d);
      wait_level(1'b0, w);
      // First+1 counts, plus pending restart, output flop and sample edge
      chk("trigger delay", 32'd8, d);
      chk("pulse width", 32'h6, w);
      repeat (30) @(posedge pclk);
      chk("single pulse", 32'h0, {31'h0, timer_output_pin});
      pins.set_pin(1'b0, 1'b1);
      wait_level(1'b1, d);
      wait_level(1'b0, w);
      // Three more pclk for the two synchroniser flops and the edge pending flop
      chk("pin delay", 32'd11, d);
      chk("pin width", 32'h6, w);
      apb(1'b1, `TOPC_OFF_MODE, 32'h0);
      pins.set_pin(1'b0, 1'b0);
   endtask
   task automatic t_capture();
      logic [31:0] df;
      int n1, n2;
      setup(32'h5, 32'hf, 32'h0, 32'h4);
      n1 = irq1_cnt;
      n2 = irq2_cnt;
      pins.set_pin(1'b0, 1'b1);
      repeat (19) @(posedge pclk);
      pins.set_pin(1'b1, 1'b1);
      repeat (10) @(posedge pclk);
      read_diff(df);
      chk("two-input width", 32'd20, df);
      chk("first irq by second pin", 32'd1, irq1_cnt - n1);
      chk("second irq by first pin", 32'd1, irq2_cnt - n2);
      apb(1'b1, `TOPC_OFF_MODE, 32'h0);
      pins.set_pin(1'b0, 1'b0);
      pins.set_pin(1'b1, 1'b0);
      setup(32'h7, 32'h1, 32'h0, 32'h4);
      n1 = irq1_cnt;
      n2 = irq2_cnt;
      pins.set_pin(1'b0, 1'b1);
      repeat (14) @(posedge pclk);
      pins.set_pin(1'b0, 1'b0);
      repeat (10) @(posedge pclk);
      read_diff(df);
      chk("one-input width", 32'd15, df);
      chk("no irq on opposite edge", 32'd0, irq1_cnt - n1);
      chk("irq on valid edge", 32'd1, irq2_cnt - n2);
   endtask
   task automatic t_clear();
      logic [31:0] df;
      setup(32'h7, 32'h1, 32'h0, 32'h8);
      pins.set_pin(1'b0, 1'b1);
      repeat (11) @(posedge pclk);
      pins.set_pin(1'b0, 1'b0);
      repeat (17) @(posedge pclk);
      pins.set_pin(1'b0, 1'b1);
      repeat (5) @(posedge pclk);
      apb(1'b0, `TOPC_OFF_CNT, 32'h0);
      chk("counter cleared", 32'h3, rd);
      read_diff(df);
      chk("low phase", 32'd18, {16'h0, 16'h0 - df[15:0]});
      // No wrap seen, so the captured cycle needs no correction
      apb(1'b0, `TOPC_OFF_MODE, 32'h0);
      chk("no wrap in cycle", 32'h8, rd);
      apb(1'b1, `TOPC_OFF_MODE, 32'h0);
      pins.set_pin(1'b0, 1'b0);
   endtask
   task automatic t_overflow();
      apb(1'b1, `TOPC_OFF_MODE, 32'h4);
      repeat (65540) @(posedge pclk);
      apb(1'b0, `TOPC_OFF_MODE, 32'h0);
      chk("overflow set", 32'h5, rd);
      apb(1'b1, `TOPC_OFF_MODE, 32'h4);
      apb(1'b0, `TOPC_OFF_MODE, 32'h0);
      chk("overflow cleared", 32'h4, rd);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ppg();
      t_oneshot();
      t_capture();
      t_clear();
      t_overflow();
      report_and_stop();
   end
endmodule // topc_timer_tb
`default_nettype wire

// >>> logic/topc_consts.vh
/*
 * Constants of the one-shot, pulse and capture timer: register offsets,
 * field positions, reset values and mode codes.
 * Assumes a 32-bit APB with byte addresses and word-aligned registers.
 */
`ifndef TOPC_CONSTS_VH
`define TOPC_CONSTS_VH

// Register byte offsets
`define TOPC_OFF_MODE 8'h00
`define TOPC_OFF_CAPCMP 8'h04
`define TOPC_OFF_OUT 8'h08
`define TOPC_OFF_EDGE 8'h0c
`define TOPC_OFF_CNT 8'h10
`define TOPC_OFF_FIRST 8'h14
`define TOPC_OFF_SECOND 8'h18
`define TOPC_OFF_PRESC 8'h1c

// Mode control fields
`define TOPC_MODE_OVF 0
`define TOPC_MODE_INV 1
`define TOPC_MODE_LO 2
`define TOPC_MODE_HI 3
`define TOPC_MODE_STOP 2'h0
`define TOPC_MODE_FREE 2'h1
`define TOPC_MODE_EDGE 2'h2
`define TOPC_MODE_MATCH 2'h3

// Capture/compare control fields
`define TOPC_CC_FIRST_CAP 0
`define TOPC_CC_FIRST_SRC 1
`define TOPC_CC_SECOND_CAP 2

// Output control fields
`define TOPC_OC_ENABLE 0
`define TOPC_OC_INV_FIRST 1
`define TOPC_OC_INV_SECOND 4
`define TOPC_OC_OS_EN 5
`define TOPC_OC_OS_TRIG 6

// Edge select codes
`define TOPC_EDGE_FALL 2'h0
`define TOPC_EDGE_RISE 2'h1
`define TOPC_EDGE_BOTH 2'h3

// Widths, limits and reset values
`define TOPC_CNT_MAX 16'hffff
`define TOPC_CNT_ZERO 16'h0000
`define TOPC_RST_BYTE 8'h00
`define TOPC_RST_WORD 16'h0000

`endif

// >>> logic/topc_edge_sync.v
/*
 * Two-flop synchroniser with rise and fall pulse detection for one pin.
 * Assumes the pin is asynchronous to pclk and is slow enough that each
 * level lasts at least two pclk cycles.
 */
`default_nettype none

module topc_edge_sync (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Pin and detected edges
   input wire pin,
   output wire rise,
   output wire fall
);

   reg meta;
   reg sync;
   reg prev;

   // Meta feeds only the second flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign rise = sync & ~prev;
   assign fall = ~sync & prev;

endmodule // topc_edge_sync

`default_nettype wire

// >>> logic/topc_timer.v
/*
 * 16-bit up-counting timer with two capture/compare registers, one output
 * pin, two capture pins, one-shot and programmable pulse output and pulse
 * width capture, reached over APB.
 * Assumes capture pins are asynchronous and that software keeps the
 * setting rules that bind it.
 */
// Functional notes
// - Pulse period and duty follow compare values
// - One-shot only in free or edge modes
// - Trigger clears counter and emits one pulse
// - First match raises event and toggles output
// - Second match raises event and toggles output
// - Pulse delay and width from compare values
// - Overflow flag set by hardware, cleared
// - Two-input free-run captures cross over
// - Single input: opposite edge first, valid second
// - Edge mode: valid edge captures then clears
// - Free-run wraps to zero and flags overflow
`default_nettype none
`include "topc_consts.vh"

module topc_timer (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Capture pins
   input wire first_capture_input,
   input wire second_capture_input,
   // Timer output and events
   output reg timer_output_pin,
   output reg first_match_irq,
   output reg second_match_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function valid_edge;
      input [1:0] sel;
      input r;
      input f;
      begin
         if (sel == `TOPC_EDGE_RISE)
            valid_edge = r;
         else if (sel == `TOPC_EDGE_BOTH)
            valid_edge = r | f;
         else
            valid_edge = f;
      end
   endfunction

   // Both-edge selection has no opposite edge
   function opp_edge;
      input [1:0] sel;
      input r;
      input f;
      begin
         if (sel == `TOPC_EDGE_RISE)
            opp_edge = f;
         else if (sel == `TOPC_EDGE_BOTH)
            opp_edge = 1'b0;
         else
            opp_edge = r;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg [1:0] mode_field;
   reg mode_invert;
   reg overflow_flag;
   reg [2:0] capcmp_ctrl;
   reg [5:0] output_ctrl;
   reg [1:0] first_edge_sel;
   reg [1:0] second_edge_sel;
   reg [7:0] prescaler_mode;
   reg [15:0] up_counter;
   reg [15:0] first_cap_cmp;
   reg [15:0] second_cap_cmp;
   reg [7:0] presc_cnt;
   reg out_level;
   reg one_shot_busy;
   reg sw_trig_pend;
   reg edge_clr_pend;

   wire first_rise;
   wire first_fall;
   wire second_rise;
   wire second_fall;

   topc_edge_sync u_first_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(first_capture_input),
      .rise(first_rise),
      .fall(first_fall)
   );

   topc_edge_sync u_second_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(second_capture_input),
      .rise(second_rise),
      .fall(second_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode

   wire running = (mode_field != `TOPC_MODE_STOP);
   wire wr_acc = psel & penable & pready & pwrite;
   wire rd_req = psel & penable & ~pready & ~pwrite;
   wire tick = running & (presc_cnt == prescaler_mode);
   wire first_is_cap = capcmp_ctrl[`TOPC_CC_FIRST_CAP];
   wire second_is_cap = capcmp_ctrl[`TOPC_CC_SECOND_CAP];
   wire first_src_own = capcmp_ctrl[`TOPC_CC_FIRST_SRC];
   wire os_en = output_ctrl[`TOPC_OC_OS_EN];
   wire os_mode = os_en & ((mode_field == `TOPC_MODE_FREE) |
                           (mode_field == `TOPC_MODE_EDGE));
   wire first_valid = running &
                      valid_edge(first_edge_sel, first_rise, first_fall);
   wire first_opp = running &
                    opp_edge(first_edge_sel, first_rise, first_fall);
   wire second_valid = running &
                       valid_edge(second_edge_sel, second_rise, second_fall);
   wire wr_mode = wr_acc & (paddr == `TOPC_OFF_MODE);
   wire wr_out = wr_acc & (paddr == `TOPC_OFF_OUT);
   wire sw_trig = wr_out & pwdata[`TOPC_OC_OS_TRIG] & running;

   // Edge valid in edge mode, or any one-shot trigger, restarts the count
   wire restart_req = sw_trig_pend | edge_clr_pend;
   wire match_first = tick & ~first_is_cap & (up_counter == first_cap_cmp);
   wire match_second = tick & ~second_is_cap &
                       (up_counter == second_cap_cmp);
   wire match_clear = (mode_field == `TOPC_MODE_MATCH) & match_first;
   wire wrap = tick & (up_counter == `TOPC_CNT_MAX) & ~restart_req;

   // Capture sources; input source select picks the first register's source only
   wire cap_first_by_second = first_is_cap & ~first_src_own & second_valid;
   wire cap_first_by_opp = first_is_cap & first_src_own & first_opp;
   wire cap_second = second_is_cap & first_valid;

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, errors on unmapped offsets

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (psel & penable & ~pready) begin
            prdata <= 32'h00000000;
            if (paddr == `TOPC_OFF_MODE) begin
               if (rd_req)
                  prdata <= {28'h0000000, mode_field, mode_invert,
                             overflow_flag};
            end else if (paddr == `TOPC_OFF_CAPCMP) begin
               if (rd_req)
                  prdata <= {29'h00000000, capcmp_ctrl};
            end else if (paddr == `TOPC_OFF_OUT) begin
               // Trigger bit always reads zero
               if (rd_req)
                  prdata <= {26'h0000000, output_ctrl};
            end else if (paddr == `TOPC_OFF_EDGE) begin
               if (rd_req)
                  prdata <= {28'h0000000, second_edge_sel, first_edge_sel};
            end else if (paddr == `TOPC_OFF_CNT) begin
               if (rd_req)
                  prdata <= {16'h0000, up_counter};
            end else if (paddr == `TOPC_OFF_FIRST) begin
               if (rd_req)
                  prdata <= {16'h0000, first_cap_cmp};
            end else if (paddr == `TOPC_OFF_SECOND) begin
               if (rd_req)
                  prdata <= {16'h0000, second_cap_cmp};
            end else if (paddr == `TOPC_OFF_PRESC) begin
               if (rd_req)
                  prdata <= {24'h000000, prescaler_mode};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_field <= `TOPC_MODE_STOP;
         mode_invert <= 1'b0;
         capcmp_ctrl <= 3'h0;
         output_ctrl <= 6'h00;
         first_edge_sel <= `TOPC_EDGE_FALL;
         second_edge_sel <= `TOPC_EDGE_FALL;
         prescaler_mode <= `TOPC_RST_BYTE;
      end else if (wr_acc) begin
         if (paddr == `TOPC_OFF_MODE) begin
            mode_field <= pwdata[`TOPC_MODE_HI:`TOPC_MODE_LO];
            mode_invert <= pwdata[`TOPC_MODE_INV];
         end else if (paddr == `TOPC_OFF_CAPCMP) begin
            capcmp_ctrl <= pwdata[2:0];
         end else if (paddr == `TOPC_OFF_OUT) begin
            output_ctrl <= pwdata[5:0];
         end else if (paddr == `TOPC_OFF_EDGE) begin
            // Taken at any time; only meaningful while stopped
            first_edge_sel <= pwdata[1:0];
            second_edge_sel <= pwdata[3:2];
         end else if (paddr == `TOPC_OFF_PRESC) begin
            prescaler_mode <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count clock enable

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         presc_cnt <= `TOPC_RST_BYTE;
      else if (!running || tick)
         presc_cnt <= `TOPC_RST_BYTE;
      else
         presc_cnt <= presc_cnt + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending restarts, applied at the next count clock

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_trig_pend <= 1'b0;
         edge_clr_pend <= 1'b0;
      end else if (!running) begin
         sw_trig_pend <= 1'b0;
         edge_clr_pend <= 1'b0;
      end else begin
         if (sw_trig && os_mode)
            sw_trig_pend <= 1'b1;
         else if (tick)
            sw_trig_pend <= 1'b0;
         if (first_valid && (mode_field == `TOPC_MODE_EDGE ||
                             os_mode))
            edge_clr_pend <= 1'b1;
         else if (tick)
            edge_clr_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and overflow flag

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         up_counter <= `TOPC_CNT_ZERO;
      else if (!running)
         up_counter <= `TOPC_CNT_ZERO;
      else if (tick) begin
         if (restart_req)
            up_counter <= `TOPC_CNT_ZERO;
         else if (match_clear)
            up_counter <= `TOPC_CNT_ZERO;
         else
            up_counter <= up_counter + 16'h0001;
      end
   end

   // Set wins over a software clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         overflow_flag <= 1'b0;
      else if (wrap)
         overflow_flag <= 1'b1;
      else if (wr_mode && !pwdata[`TOPC_MODE_OVF])
         overflow_flag <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture/compare registers

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cap_cmp <= `TOPC_RST_WORD;
         second_cap_cmp <= `TOPC_RST_WORD;
      end else begin
         if (cap_first_by_second)
            first_cap_cmp <= up_counter;
         else if (cap_first_by_opp)
            first_cap_cmp <= up_counter;
         else if (wr_acc && paddr == `TOPC_OFF_FIRST)
            first_cap_cmp <= pwdata[15:0];
         if (cap_second)
            second_cap_cmp <= up_counter;
         else if (wr_acc && paddr == `TOPC_OFF_SECOND)
            second_cap_cmp <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events, one pclk each; opposite-edge capture raises none

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_match_irq <= 1'b0;
         second_match_irq <= 1'b0;
      end else begin
         first_match_irq <= match_first | cap_first_by_second;
         second_match_irq <= match_second | cap_second;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output level

   // A new trigger during a pulse restarts it; software must avoid that
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= 1'b0;
         one_shot_busy <= 1'b0;
      end else if (!running) begin
         out_level <= 1'b0;
         one_shot_busy <= 1'b0;
      end else if (os_mode) begin
         if (tick && restart_req) begin
            out_level <= 1'b0;
            one_shot_busy <= 1'b1;
         end else if (one_shot_busy && match_first) begin
            out_level <= ~out_level;
         end else if (one_shot_busy && match_second) begin
            out_level <= ~out_level;
            one_shot_busy <= 1'b0;
         end
      end else if (mode_field == `TOPC_MODE_MATCH) begin
         // High from clear through the width match
         if (match_clear)
            out_level <= 1'b1;
         else if (match_second)
            out_level <= 1'b0;
      end else begin
         if ((match_first && output_ctrl[`TOPC_OC_INV_FIRST]) ^
             (match_second && output_ctrl[`TOPC_OC_INV_SECOND]))
            out_level <= ~out_level;
         else if (mode_invert && first_valid)
            out_level <= ~out_level;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         timer_output_pin <= 1'b0;
      else
         timer_output_pin <= out_level & output_ctrl[`TOPC_OC_ENABLE];
   end

   // Software adds wraps itself

endmodule // topc_timer

`default_nettype wire
